// >>> verilog/ees_slave.sv
// two-wire eeprom bus slave front end with receive fifo and synchronisers
`timescale 1ns/1ps

// two flip-flop level synchroniser
module ees_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // destination clock
   input logic clk,
   input logic rst,
   // crossing level
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   // first stage feeds the second stage only
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

`timescale 1ns/1ps

// small flop fifo with valid and ready on both sides
module ees_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // clock and reset
   input logic clock,
   input logic rst,
   // filling side
   input logic [WIDTH-1:0] in_data,
   input logic in_valid,
   output logic in_ready,
   // draining side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
      $error("fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;

   // extra pointer bit tells full from empty
   assign in_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
   assign out_valid = wr_ptr_ff != rd_ptr_ff;
   assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

   // write side
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr_ff <= '0;
      end else if (in_valid && in_ready) begin
         wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
   end

   // storage needs no reset, pointers guard it
   always_ff @(posedge clock) begin
      if (in_valid && in_ready) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   // read side
   always_ff @(posedge clock) begin
      if (rst) begin
         rd_ptr_ff <= '0;
      end else if (out_valid && out_ready) begin
         rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end
endmodule

`timescale 1ns/1ps

// bus slave: start/stop, bit shifting, acknowledge and select decode
module ees_slave import ees_pkg::*; #(
   parameter logic [3:0] DEV_TYPE = 4'h6 // arbitrary type code
) (
   // system clock and reset
   input logic clock,
   input logic rst,
   // link clock and bus pins
   input logic link_clk,
   input logic scl_i,
   input logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input logic [2:0] chip_select_inputs,
   // memory core side
   input logic prog_busy,
   output logic wr_cycle_start,
   output logic standby,
   output ees_byte_t rx_byte,
   output logic rx_valid,
   input logic rx_ready,
   output logic rd_req,
   input logic [7:0] rd_data
);
   // link domain signals
   logic lrst;
   logic [7:0] lnk_s;
   logic scl_s, sda_s, busy_s, rx_ack_s, rd_ack_s;
   logic [2:0] cs_s;
   logic scl_d_ff, sda_d_ff;
   logic scl_rise, scl_fall, start_det, stop_det;
   ees_state_t state_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff, tx_sh_ff, tx_load;
   logic sel_phase_ff, txn_ff, rw_ff, first_ff, sda_oe_ff;
   logic rx_req_ff, rd_tgl_ff, wr_tgl_ff;
   ees_byte_t rx_hold_ff;
   logic sel_match, rx_pend, byte_done, sel_take, data_take;
   logic ack_leave, go_tx, tx_end;
   // system domain signals
   logic [3:0] sys_s;
   logic rx_req_s, rd_tgl_s, wr_tgl_s, txn_s;
   logic rx_ack_ff, rd_ack_ff, wr_seen_ff, wr_start_ff;
   logic [7:0] rd_hold_ff;
   logic fifo_in_ready;

   // link reset follows system reset, released on link clock
   ees_sync #(.W(1), .RST_VAL(1'b1)) u_lrst (
      .clk(link_clk),
      .rst(1'b0),
      .d(rst),
      .q(lrst)
   );

   // all pins and handshake returns pass two flops
   ees_sync #(.W(8), .RST_VAL(LNK_SYNC_RST)) u_lsync (
      .clk(link_clk),
      .rst(lrst),
      .d({scl_i, sda_i, chip_select_inputs, prog_busy, rx_ack_ff, rd_ack_ff}),
      .q(lnk_s)
   );
   assign {scl_s, sda_s, cs_s, busy_s, rx_ack_s, rd_ack_s} = lnk_s;

   // previous levels for edge detection
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   // bus events; a start is ignored while the array programs
   assign scl_rise = scl_s && !scl_d_ff;
   assign scl_fall = !scl_s && scl_d_ff;
   assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s && !busy_s;
   assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;

   // select word decode, msb first into the shifter
   assign sel_match = (shift_ff[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE) &&
      (shift_ff[SEL_CE_MSB:SEL_CE_LSB] == cs_s);
   assign rx_pend = rx_req_ff != rx_ack_s;
   assign byte_done = (state_ff == ST_RX) && scl_fall && (cnt_ff == BIT_CNT_LAST);
   assign sel_take = byte_done && sel_phase_ff && sel_match;
   assign data_take = byte_done && !sel_phase_ff && !rx_pend;
   assign ack_leave = (state_ff == ST_ACK) && scl_fall && (cnt_ff != BIT_CNT_INIT);
   assign go_tx = scl_fall && (cnt_ff != BIT_CNT_INIT) &&
      (((state_ff == ST_ACK) && rw_ff) || (state_ff == ST_MACK));
   assign tx_end = (state_ff == ST_TX) && scl_fall && (cnt_ff == BIT_CNT_LAST);
   // core too slow: send all ones rather than stale data
   assign tx_load = (rd_ack_s == rd_tgl_ff) ? rd_hold_ff : TX_IDLE_BYTE;

   // bus state
   always_ff @(posedge link_clk) begin
      if (lrst || stop_det) begin
         state_ff <= ST_IDLE;
      end else if (start_det) begin
         state_ff <= ST_RX;
      end else begin
         unique case (state_ff)
            ST_IDLE: state_ff <= ST_IDLE;
            ST_RX: begin
               if (byte_done) begin
                  state_ff <= (sel_phase_ff && !sel_match) ? ST_IDLE : ST_ACK;
               end
            end
            ST_ACK: begin
               if (ack_leave) begin
                  state_ff <= go_tx ? ST_TX : ST_RX;
               end
            end
            ST_TX: begin
               if (tx_end) begin
                  state_ff <= ST_MACK;
               end
            end
            ST_MACK: begin
               if (scl_rise && sda_s) begin
                  state_ff <= ST_IDLE; // master declined, wait for stop
               end else if (go_tx) begin
                  state_ff <= ST_TX;
               end
            end
         endcase
      end
   end

   // bit counter counts rising edges of the clock
   always_ff @(posedge link_clk) begin
      if (lrst || start_det || stop_det) begin
         cnt_ff <= BIT_CNT_INIT;
      end else if (scl_rise && (state_ff != ST_IDLE)) begin
         cnt_ff <= cnt_ff + 4'h1;
      end else if (byte_done || ack_leave || go_tx || tx_end) begin
         cnt_ff <= BIT_CNT_INIT;
      end
   end

   // receive shifter; master keeps data steady over the rise
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         shift_ff <= 8'h00;
      end else if ((state_ff == ST_RX) && scl_rise) begin
         shift_ff <= {shift_ff[6:0], sda_s};
      end
   end

   // first byte after a start is the select word
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         sel_phase_ff <= 1'b0;
      end else if (start_det) begin
         sel_phase_ff <= 1'b1;
      end else if (ack_leave || stop_det) begin
         sel_phase_ff <= 1'b0;
      end
   end

   // transaction and direction; a repeated start cancels a pending write
   always_ff @(posedge link_clk) begin
      if (lrst || start_det || stop_det) begin
         txn_ff <= 1'b0;
      end else if (sel_take) begin
         txn_ff <= 1'b1;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         rw_ff <= 1'b0;
      end else if (sel_take) begin
         rw_ff <= shift_ff[SEL_RW_BIT];
      end
   end

   // write cycle launch event, crossed as a toggle
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         wr_tgl_ff <= 1'b0;
      end else if (stop_det && txn_ff && (rw_ff != DIR_READ)) begin
         wr_tgl_ff <= !wr_tgl_ff;
      end
   end

   // received bytes cross by a toggle handshake; hold stays put while pending
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         first_ff <= 1'b0;
         rx_req_ff <= 1'b0;
         rx_hold_ff <= '0;
      end else if (sel_take) begin
         first_ff <= 1'b1;
      end else if (data_take) begin
         first_ff <= 1'b0;
         rx_req_ff <= !rx_req_ff;
         rx_hold_ff <= '{first: first_ff, data: shift_ff};
      end
   end

   // read byte requests: one on a read select, then one prefetch per load
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         rd_tgl_ff <= 1'b0;
      end else if ((sel_take && (shift_ff[SEL_RW_BIT] == DIR_READ)) || go_tx) begin
         rd_tgl_ff <= !rd_tgl_ff;
      end
   end

   // data line drive, changed on falling clock edges and released at a start or stop
   always_ff @(posedge link_clk) begin
      if (lrst || start_det || stop_det) begin
         sda_oe_ff <= 1'b0;
         tx_sh_ff <= TX_IDLE_BYTE;
      end else if (byte_done) begin
         // full buffer refuses the byte by not acknowledging it
         sda_oe_ff <= sel_phase_ff ? sel_match : !rx_pend;
      end else if (go_tx) begin
         tx_sh_ff <= tx_load;
         sda_oe_ff <= !tx_load[7];
      end else if (ack_leave) begin
         sda_oe_ff <= 1'b0;
      end else if (tx_end) begin
         sda_oe_ff <= 1'b0;
      end else if ((state_ff == ST_TX) && scl_fall) begin
         tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
         sda_oe_ff <= !tx_sh_ff[6];
      end
   end

   // open drain: only ever pulls low, never touches the clock
   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_ff;

   // system side receives the link levels through two flops
   ees_sync #(.W(4), .RST_VAL(4'h0)) u_ssync (
      .clk(clock),
      .rst(rst),
      .d({rx_req_ff, rd_tgl_ff, wr_tgl_ff, txn_ff}),
      .q(sys_s)
   );
   assign {rx_req_s, rd_tgl_s, wr_tgl_s, txn_s} = sys_s;

   // push a pending byte when the fifo has room, then acknowledge
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_ack_ff <= 1'b0;
      end else if ((rx_req_s != rx_ack_ff) && fifo_in_ready) begin
         rx_ack_ff <= rx_req_s;
      end
   end

   ees_fifo #(.WIDTH(RX_WORD_W), .DEPTH(RX_FIFO_DEPTH)) u_rx_fifo (
      .clock(clock),
      .rst(rst),
      .in_data(rx_hold_ff),
      .in_valid(rx_req_s != rx_ack_ff),
      .in_ready(fifo_in_ready),
      .out_data(rx_byte),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   // read data is taken in the cycle of the request
   assign rd_req = rd_tgl_s != rd_ack_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         rd_ack_ff <= 1'b0;
         rd_hold_ff <= TX_IDLE_BYTE;
      end else if (rd_req) begin
         rd_ack_ff <= rd_tgl_s;
         rd_hold_ff <= rd_data;
      end
   end

   // write cycle pulse and standby level
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_seen_ff <= 1'b0;
         wr_start_ff <= 1'b0;
      end else begin
         wr_seen_ff <= wr_tgl_s;
         wr_start_ff <= wr_tgl_s != wr_seen_ff;
      end
   end
   assign wr_cycle_start = wr_start_ff;
   assign standby = !txn_s;

   // checks on the link side logic
   default clocking @(posedge link_clk); endclocking
   default disable iff (lrst);

   a_slave_drive: assert property (
      sda_oe |-> (state_ff == ST_ACK) || (state_ff == ST_TX))
      else $error("data driven outside acknowledge or transmit");
   a_start_seen: assert property (
      start_det |=> (state_ff == ST_RX) && (cnt_ff == BIT_CNT_INIT) && sel_phase_ff)
      else $error("start not taken");
   a_idle_quiet: assert property (
      (state_ff == ST_IDLE) && !start_det |=> (state_ff == ST_IDLE) && !sda_oe)
      else $error("idle slave reacted without start");
   a_stop_ends: assert property (
      stop_det |=> (state_ff == ST_IDLE) && !txn_ff && !sda_oe)
      else $error("stop did not end the transaction");
   a_stop_read: assert property (
      stop_det && txn_ff && rw_ff |=> $stable(wr_tgl_ff) ##1 !txn_ff)
      else $error("stop after read launched a write");
   a_stop_write: assert property (
      stop_det && txn_ff && !rw_ff |=> wr_tgl_ff != $past(wr_tgl_ff))
      else $error("stop after write did not launch the write cycle");
   a_tx_release: assert property (
      tx_end |=> !sda_oe && (state_ff == ST_MACK))
      else $error("data not released after eight bits");
   a_ack_hold: assert property (
      byte_done && sel_take |=> sda_oe [*1] ##0 (state_ff == ST_ACK))
      else $error("matching select not acknowledged");
   a_rise_sample: assert property (
      (state_ff == ST_RX) && scl_rise |=> shift_ff[0] == $past(sda_s))
      else $error("data not sampled on rising clock");
   a_dir_capture: assert property (
      sel_take |=> txn_ff && (rw_ff == $past(shift_ff[SEL_RW_BIT])))
      else $error("direction bit not captured");
   a_no_match: assert property (
      byte_done && sel_phase_ff && !sel_match |=> (state_ff == ST_IDLE) && !sda_oe)
      else $error("mismatched select answered");

   c_write_stop: cover property (stop_det && txn_ff && !rw_ff);
   c_read_stop: cover property (stop_det && txn_ff && rw_ff);
   c_mismatch: cover property (byte_done && sel_phase_ff && !sel_match);
   c_master_nack: cover property ((state_ff == ST_MACK) && scl_rise && sda_s);
endmodule

// >>> verilog/ees_pkg.sv
// constants and carrier types for the serial eeprom two-wire bus slave
package ees_pkg;
   // select word layout
   localparam int SEL_TYPE_MSB = 7;
   localparam int SEL_TYPE_LSB = 4;
   localparam int SEL_CE_MSB = 3;
   localparam int SEL_CE_LSB = 1;
   localparam int SEL_RW_BIT = 0;
   localparam logic DIR_READ = 1'b1;
   // bit counter values
   localparam logic [3:0] BIT_CNT_INIT = 4'h0;
   localparam logic [3:0] BIT_CNT_LAST = 4'h8;
   // byte sent when the core has not answered in time
   localparam logic [7:0] TX_IDLE_BYTE = 8'hff;
   // receive buffer shape
   localparam int RX_FIFO_DEPTH = 4;
   localparam int RX_WORD_W = 9;
   // link sync reset value: scl and sda idle high, the rest low
   localparam logic [7:0] LNK_SYNC_RST = 8'hc0;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_MACK = 5'h10
   } ees_state_t;

   typedef struct packed {
      logic first;
      logic [7:0] data;
   } ees_byte_t;
endpackage

// >>> testbench/ees_master_model.sv
// two-wire bus master model that makes scl and its share of sda
`timescale 1ns/1ps
module ees_master_model (
   // timing reference
   input wire logic clock,
   // bus lines
   input wire logic sda,
   output logic scl,
   output logic m_oe
);
   // a quarter bit is three system clocks, long beside the slave's sync delay
   task automatic step();
      repeat (3) @(posedge clock);
      #1;
   endtask
   // data moves only while scl is low
   task automatic bit_wr(input logic b);
      m_oe = !b;
      step();
      scl = 1'b1;
      step();
      step();
      scl = 1'b0;
      step();
   endtask
   // released line: the pull-up or the slave sets the level
   task automatic bit_rd(output logic r);
      m_oe = 1'b0;
      step();
      scl = 1'b1;
      step();
      r = sda;
      step();
      scl = 1'b0;
      step();
   endtask
   // also serves as a repeated start from scl low
   task automatic start();
      m_oe = 1'b0;
      step();
      scl = 1'b1;
      step();
      m_oe = 1'b1;
      step();
      scl = 1'b0;
      step();
   endtask
   // leaves both lines released, scl stands high until the next frame
   task automatic stop();
      m_oe = 1'b1;
      step();
      scl = 1'b1;
      step();
      m_oe = 1'b0;
      step();
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack_n);
      for (int i = 7; i >= 0; i--) bit_wr(b[i]);
      bit_rd(ack_n);
   endtask
   task automatic rd_byte(output logic [7:0] d, input logic ack_n);
      for (int i = 7; i >= 0; i--) bit_rd(d[i]);
      bit_wr(ack_n);
   endtask
   // idle bus
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the two-wire eeprom bus slave front end
`timescale 1ns/1ps
module testbench import ees_pkg::*;;
   localparam logic [3:0] TYPE_CODE = 4'h6; // arbitrary type code
   typedef struct packed {
      logic [2:0] ce;
      logic [7:0] sel;
      logic [7:0] data;
      logic ack_n;
   } ees_row_t;
   logic clock = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] ce_pins = 3'h0;
   logic prog_busy = 1'b0;
   logic rx_ready = 1'b1;
   logic [7:0] rd_data = 8'h00;
   logic scl, m_oe, sda_o, sda_oe, wr_cycle_start, standby, rx_valid, rd_req;
   ees_byte_t rx_byte;
   wire sda = !m_oe & (sda_oe ? sda_o : 1'b1);
   int error_cnt = 0;
   int comparisons = 0;
   int wr_cnt = 0;
   int rd_cnt = 0;
   int rd_base;
   int base;
   logic ack_n;
   logic [7:0] rd, rd2;
   logic [5:0] acks;
   ees_byte_t got_q[$];
   // select on each side of every field boundary, both directions
   ees_row_t rows [7] = '{
      '{3'h5, {TYPE_CODE, 3'h5, 1'b0}, 8'h3c, 1'b0},
      '{3'h2, {TYPE_CODE, 3'h2, 1'b1}, 8'hc3, 1'b0},
      '{3'h0, {TYPE_CODE, 3'h1, 1'b0}, 8'h00, 1'b1},
      '{3'h7, {~TYPE_CODE, 3'h7, 1'b1}, 8'h00, 1'b1},
      '{3'h4, {TYPE_CODE, 3'h0, 1'b1}, 8'h00, 1'b1},
      '{3'h7, {TYPE_CODE, 3'h7, 1'b0}, 8'h81, 1'b0},
      '{3'h0, {TYPE_CODE, 3'h0, 1'b1}, 8'h01, 1'b0}};

   // system clock, and a link clock offset so the phases never line up
   always #50 clock = ~clock;
   initial begin
      #3.1;
      forever #7.5 link_clk = ~link_clk;
   end

   ees_slave #(.DEV_TYPE(TYPE_CODE)) dut (.clock(clock), .rst(rst), .link_clk(link_clk),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .chip_select_inputs(ce_pins), .prog_busy(prog_busy), .wr_cycle_start(wr_cycle_start),
      .standby(standby), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rd_req(rd_req), .rd_data(rd_data));
   ees_master_model m (.clock(clock), .sda(sda), .scl(scl), .m_oe(m_oe));

   // core side: count write launches and read requests, collect popped bytes
   always @(posedge clock) begin
      if (!rst && wr_cycle_start === 1'b1) wr_cnt++;
      if (!rst && rd_req === 1'b1) rd_cnt++;
      if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_byte);
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // bounded wait for one write launch; running out ends the run
   task automatic expect_wr(input int b);
      for (int i = 0; i < 40 && wr_cnt == b; i++) cycles(1);
      check(9'(wr_cnt), 9'(b + 1));
      if (wr_cnt == b) report_and_stop();
   endtask

   // hang guard
   initial begin
      cycles(90000);
      error_cnt++;
      report_and_stop();
   end

   // main sequence
   initial begin
      cycles(12);
      check(9'({standby, sda_oe, rx_valid}), 9'h4);
      rst = 1'b0;
      cycles(10);
      foreach (rows[r]) begin
         ce_pins = rows[r].ce;
         rd_data = rows[r].data;
         base = wr_cnt;
         rd_base = rd_cnt;
         m.start();
         m.wr_byte(rows[r].sel, ack_n);
         check(9'(ack_n), 9'(rows[r].ack_n));
         if (ack_n) begin
            m.wr_byte(8'h55, ack_n);
            check(9'(ack_n), 9'h1);
            m.stop();
            cycles(20);
            check(9'(wr_cnt), 9'(base));
         end else if (rows[r].sel[0] === DIR_READ) begin
            check(9'(standby), 9'h0);
            m.rd_byte(rd, 1'b1);
            check(9'(rd), 9'(rows[r].data));
            m.stop();
            cycles(20);
            check(9'(wr_cnt), 9'(base));
         end else begin
            m.wr_byte(rows[r].data, ack_n);
            check(9'(ack_n), 9'h0);
            m.stop();
            expect_wr(base);
            check(9'(got_q.pop_front()), {1'b1, rows[r].data});
         end
         check(9'(standby), 9'h1);
         check(9'(got_q.size()), 9'h0);
         // one fetch at the read select and one prefetch at the byte load
         check(9'(rd_cnt - rd_base), (!rows[r].ack_n && rows[r].sel[0]) ? 9'h2 : 9'h0);
      end
      // buffer filled with the core stalled, then drained
      rx_ready = 1'b0;
      base = wr_cnt;
      m.start();
      m.wr_byte({TYPE_CODE, ce_pins, 1'b0}, ack_n);
      for (int i = 0; i < 6; i++) m.wr_byte(8'h10 + 8'(i), acks[i]);
      m.stop();
      expect_wr(base);
      check(9'(acks[4:0]), 9'h0);
      check(9'(acks[5]), 9'h1);
      rx_ready = 1'b1;
      cycles(10);
      check(9'(got_q.size()), 9'(6 - $countones(acks)));
      foreach (got_q[k]) check(got_q[k], {k == 0, 8'h10 + 8'(k)});
      got_q.delete();
      // start during a programming cycle is ignored
      prog_busy = 1'b1;
      base = wr_cnt;
      m.start();
      m.wr_byte({TYPE_CODE, ce_pins, 1'b0}, ack_n);
      check(9'(ack_n), 9'h1);
      m.stop();
      prog_busy = 1'b0;
      cycles(20);
      check(9'(wr_cnt), 9'(base));
      // write turned into a read by a repeated start, two bytes read
      rd_data = 8'h96;
      base = wr_cnt;
      rd_base = rd_cnt;
      m.start();
      m.wr_byte({TYPE_CODE, ce_pins, 1'b0}, ack_n);
      m.wr_byte(8'h77, ack_n);
      m.start();
      m.wr_byte({TYPE_CODE, ce_pins, 1'b1}, ack_n);
      check(9'(ack_n), 9'h0);
      m.rd_byte(rd, 1'b0);
      m.rd_byte(rd2, 1'b1);
      check(9'(rd), 9'h96);
      check(9'(rd2), 9'h96);
      m.stop();
      cycles(20);
      check(9'(wr_cnt), 9'(base));
      check(9'(rd_cnt - rd_base), 9'h3);
      check(9'(got_q.pop_front()), 9'h177);
      // reset in mid-frame drops the transaction
      m.start();
      m.wr_byte({TYPE_CODE, ce_pins, 1'b0}, ack_n);
      rst = 1'b1;
      cycles(12);
      check(9'({standby, sda_oe, rx_valid}), 9'h4);
      rst = 1'b0;
      cycles(10);
      // a select word with no start ahead of it gets no answer
      m.wr_byte({TYPE_CODE, ce_pins, 1'b0}, ack_n);
      check(9'(ack_n), 9'h1);
      m.stop();
      cycles(20);
      check(9'(wr_cnt), 9'(base));
      report_and_stop();
   end
endmodule
